// [design/star_delta_pole_starter.sv]
`timescale 1ns/1ps

module star_delta_pole_starter #(
  parameter int unsigned MS_TICK_CYCLES = starter_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // plant inputs
  input  wire logic        checkback_input_i,
  input  wire logic        aux_input_one_i,
  input  wire logic        aux_input_two_i,
  input  wire logic        speed_two_start_input_i,
  input  wire logic        local_start_input_i,
  input  wire logic        local_stop_input_i,
  input  wire logic        supply_dip_i,
  input  wire logic [15:0] current_sample_i,
  // contactor and lamp outputs
  output logic             relay_out_zero_o,
  output logic             relay_out_one_o,
  output logic             relay_out_two_o,
  output logic             relay_out_three_o,
  output logic             out_24v_o
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STAR,
    ST_GAP,
    ST_DELTA,
    ST_SPEED_ONE,
    ST_SPEED_TWO
  } motor_state_t;

  typedef struct packed {
    starter_pkg::pin_in_t pin_s1;
    starter_pkg::pin_in_t pin_s2;
    starter_pkg::pin_in_t pin_prev;
    logic                 dip_s1;
    logic                 dip_s2;
    starter_pkg::config_t cfg;
    logic [15:0]          star_time;
    logic [15:0]          switch_level;
    logic [15:0]          rated_one;
    logic [15:0]          rated_two;
    logic [7:0]           ct_ratio;
    logic [15:0]          cmd;
    motor_state_t         state;
    logic [31:0]          ms_div;
    logic [15:0]          ms_cnt;
    logic [15:0]          cb_cnt;
    logic                 fault;
    logic                 out_24v;
    starter_pkg::relay_t  relays;
    logic                 ack;
    logic [31:0]          rdata;
  } starter_state_t;

  localparam starter_state_t RST_STATE = '{
    cfg:          starter_pkg::RST_CONFIG,
    star_time:    starter_pkg::RST_STAR_TIME,
    switch_level: starter_pkg::RST_SWITCH_LEVEL,
    rated_one:    starter_pkg::RST_RATED,
    rated_two:    starter_pkg::RST_RATED,
    ct_ratio:     starter_pkg::RST_CT_RATIO,
    state:        ST_IDLE,
    default:      '0
  };

  starter_state_t       s;
  starter_state_t       nxt_s;
  starter_pkg::pin_in_t pins_raw;
  logic [15:0]          factor;
  logic [15:0]          rated_sel;
  logic [15:0]          pct;
  logic                 pct_valid;
  logic                 wb_take;
  logic                 wb_wr;
  logic                 cmd_wr;
  logic                 pole;
  logic                 local_ok;
  logic                 ms_tick;
  logic                 start_one;
  logic                 start_two;
  logic                 stop_req;
  logic                 dip_trip;
  logic                 star_done;
  logic                 mismatch;
  logic                 expect_cb;
  logic                 fault_set;
  logic                 fault_clr;
  logic                 overload;
  logic                 running;
  logic [15:0]          star_min;
  logic [31:0]          mon;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge for 16-bit registers
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] dat,
                                       input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) res[7:0] = dat[7:0];
    if (sel[1]) res[15:8] = dat[15:8];
    return res;
  endfunction

  assign pins_raw = '{local_stop:      local_stop_input_i,
                      local_start:     local_start_input_i,
                      speed_two_start: speed_two_start_input_i,
                      aux_two:         aux_input_two_i,
                      aux_one:         aux_input_one_i,
                      checkback:       checkback_input_i};

  ////////////////////////////////////////////////////////////////////////////
  // current scaling; pole mode measures against the rated current of its speed
  assign factor = 16'(s.cfg.root3 ? starter_pkg::CUR_FACTOR_ROOT3 : starter_pkg::CUR_FACTOR_DELTA)
                  * 16'(s.ct_ratio);
  assign rated_sel = (s.state == ST_SPEED_TWO) ? s.rated_two : s.rated_one;

  current_scaler current_scaler_inst (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .sample_i (current_sample_i),
    .factor_i (factor),
    .rated_i  (rated_sel),
    .pct_o    (pct),
    .valid_o  (pct_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for the whole block
  always_comb begin
    nxt_s     = s;
    wb_take   = wb_cyc_i && wb_stb_i && s.ack;
    wb_wr     = wb_take && wb_we_i;
    cmd_wr    = wb_wr && (wb_adr_i == starter_pkg::ADR_COMMAND);
    pole      = (s.cfg.function_sel == starter_pkg::FUNC_POLE_CHANGE);
    local_ok  = s.cfg.local_en && !s.cmd[starter_pkg::CMD_AUTO];
    ms_tick   = (s.ms_div == MS_TICK_CYCLES - 1);
    running   = (s.state != ST_IDLE);

    // pins pass two flops; edges are taken only on the second stage
    nxt_s.pin_s1   = pins_raw;
    nxt_s.pin_s2   = s.pin_s1;
    nxt_s.pin_prev = s.pin_s2;
    nxt_s.dip_s1   = supply_dip_i;
    nxt_s.dip_s2   = s.dip_s1;
    nxt_s.ms_div   = ms_tick ? 32'h0000_0000 : s.ms_div + 32'h0000_0001;

    // remote start commands act on the write, and only in auto mode
    start_one = (cmd_wr && wb_sel_i[0] && wb_dat_i[starter_pkg::CMD_RUN_FWD]
                 && wb_dat_i[starter_pkg::CMD_AUTO])
                || (local_ok && s.pin_s2.local_start && !s.pin_prev.local_start);
    start_two = pole && ((cmd_wr && wb_sel_i[1] && wb_dat_i[starter_pkg::CMD_RUN_FAST]
                          && s.cmd[starter_pkg::CMD_AUTO])
                || (local_ok && s.pin_s2.speed_two_start
                    && !s.pin_prev.speed_two_start));

    // ride-through only exists in pole mode
    dip_trip = s.dip_s2 && !(s.cfg.dip_ride_en && pole);

    // local stop is a level and wins in any control mode
    stop_req = (cmd_wr && wb_sel_i[0] && wb_dat_i[starter_pkg::CMD_OFF])
               || (s.cfg.local_en && s.pin_s2.local_stop)
               || s.fault || dip_trip;

    // changeover never earlier than the minimum star time
    star_min  = (s.star_time < starter_pkg::MIN_STAR_MS) ? starter_pkg::MIN_STAR_MS
                                                          : s.star_time;
    if (s.cfg.star_delta_switch_mode == starter_pkg::SWITCH_BY_TIME) begin
      star_done = (s.ms_cnt >= star_min);
    end else begin
      star_done = (s.ms_cnt >= starter_pkg::MIN_STAR_MS) && pct_valid
                  && (pct <= s.switch_level);
    end

    // motor sequencer
    if (ms_tick && s.ms_cnt != 16'hFFFF) begin
      nxt_s.ms_cnt = s.ms_cnt + 16'h0001;
    end
    case (s.state)
      ST_IDLE: begin
        nxt_s.ms_cnt = 16'h0000;
        if (!stop_req && start_one) begin
          nxt_s.state = pole ? ST_SPEED_ONE : ST_STAR;
        end else if (!stop_req && start_two) begin
          nxt_s.state = ST_SPEED_TWO;
        end
      end
      ST_STAR: begin
        if (stop_req) begin
          nxt_s.state = ST_IDLE;
        end else if (star_done) begin
          nxt_s.state  = ST_GAP;
          nxt_s.ms_cnt = 16'h0000;
        end
      end
      ST_GAP: begin
        if (stop_req) begin
          nxt_s.state = ST_IDLE;
        end else if (s.ms_cnt >= starter_pkg::CHANGE_GAP_MS) begin
          nxt_s.state = ST_DELTA;
        end
      end
      // a speed change must pass through idle, so both speeds never overlap
      default: begin
        if (stop_req) begin
          nxt_s.state = ST_IDLE;
        end
      end
    endcase

    // contactors are decoded from the next state, so they switch in the same cycle as the state
    nxt_s.relays.zero = (nxt_s.state == ST_STAR)
                        || (nxt_s.state == ST_SPEED_ONE);
    nxt_s.relays.one  = (nxt_s.state == ST_DELTA)
                        || (nxt_s.state == ST_SPEED_TWO);
    if (pole) begin
      nxt_s.relays.two   = s.cfg.fault_out_en && !s.cfg.pole_fault_relay_three
                           && s.fault;
      nxt_s.relays.three = s.cfg.fault_out_en && s.cfg.pole_fault_relay_three
                           && s.fault;
    end else begin
      nxt_s.relays.two   = (nxt_s.state == ST_STAR) || (nxt_s.state == ST_GAP)
                           || (nxt_s.state == ST_DELTA);
      nxt_s.relays.three = s.cfg.fault_out_en && s.fault;
    end

    // checkback compares the main (or speed) contactor with its auxiliary
    expect_cb = pole ? (s.relays.zero || s.relays.one) : s.relays.two;
    mismatch  = s.cfg.checkback_en && (s.pin_s2.checkback != expect_cb);
    if (!mismatch) begin
      nxt_s.cb_cnt = 16'h0000;
    end else if (ms_tick && s.cb_cnt != 16'hFFFF) begin
      nxt_s.cb_cnt = s.cb_cnt + 16'h0001;
    end
    fault_set = mismatch && (s.cb_cnt >= starter_pkg::CHECKBACK_MS);
    fault_clr = cmd_wr && wb_sel_i[0] && wb_dat_i[starter_pkg::CMD_FAULT_RESET];
    // a new fault in the reset cycle is kept
    nxt_s.fault = fault_set || (s.fault && !fault_clr);

    // 24 V output is taken over when it serves as the fault lamp
    nxt_s.out_24v = s.cfg.fault_on_24v ? s.fault
                                       : s.cmd[starter_pkg::CMD_OUT_24V];

    // register writes land on the edge where ack is seen high
    if (wb_wr) begin
      if (wb_adr_i == starter_pkg::ADR_CONFIG) begin
        if (wb_sel_i[0]) nxt_s.cfg[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) nxt_s.cfg[8] = wb_dat_i[8];
      end else if (wb_adr_i == starter_pkg::ADR_STAR_TIME) begin
        nxt_s.star_time = wr16(s.star_time, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == starter_pkg::ADR_SWITCH_LEVEL) begin
        nxt_s.switch_level = wr16(s.switch_level, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == starter_pkg::ADR_RATED_ONE) begin
        nxt_s.rated_one = wr16(s.rated_one, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == starter_pkg::ADR_RATED_TWO) begin
        nxt_s.rated_two = wr16(s.rated_two, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == starter_pkg::ADR_CT_RATIO) begin
        if (wb_sel_i[0]) nxt_s.ct_ratio = wb_dat_i[7:0];
      end else if (wb_adr_i == starter_pkg::ADR_COMMAND) begin
        nxt_s.cmd = wr16(s.cmd, wb_dat_i, wb_sel_i);
      end
    end

    // monitor image: byte zero flags, byte one speed-two flag and inputs, current word above
    overload = running && pct_valid && (pct > starter_pkg::OVERLOAD_WARN_PCT);
    mon      = 32'h0000_0000;
    mon[7]   = overload;
    mon[6]   = s.fault;
    mon[5]   = !s.cmd[starter_pkg::CMD_AUTO];
    mon[3]   = overload;
    mon[2]   = running && (s.state != ST_SPEED_TWO);
    mon[1]   = !running;
    mon[9]   = (s.state == ST_SPEED_TWO);
    mon[15:10] = s.pin_s2;
    mon[31:16] = pct;

    // one wait state: ack rises the cycle after the request and drops after
    nxt_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      if (wb_adr_i == starter_pkg::ADR_CONFIG) begin
        nxt_s.rdata = {23'h000000, s.cfg};
      end else if (wb_adr_i == starter_pkg::ADR_STAR_TIME) begin
        nxt_s.rdata = {16'h0000, s.star_time};
      end else if (wb_adr_i == starter_pkg::ADR_SWITCH_LEVEL) begin
        nxt_s.rdata = {16'h0000, s.switch_level};
      end else if (wb_adr_i == starter_pkg::ADR_RATED_ONE) begin
        nxt_s.rdata = {16'h0000, s.rated_one};
      end else if (wb_adr_i == starter_pkg::ADR_RATED_TWO) begin
        nxt_s.rdata = {16'h0000, s.rated_two};
      end else if (wb_adr_i == starter_pkg::ADR_CT_RATIO) begin
        nxt_s.rdata = {24'h000000, s.ct_ratio};
      end else if (wb_adr_i == starter_pkg::ADR_COMMAND) begin
        nxt_s.rdata = {16'h0000, s.cmd};
      end else if (wb_adr_i == starter_pkg::ADR_MONITOR) begin
        nxt_s.rdata = mon;
      end else if (wb_adr_i == starter_pkg::ADR_OUTPUTS) begin
        nxt_s.rdata = {24'h000000, 3'h0, s.out_24v, s.relays};
      end else begin
        nxt_s.rdata = 32'h0000_0000; // unmapped reads zero, writes ignored
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= RST_STATE;
    end else begin
      s <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign wb_dat_o          = s.rdata;
  assign wb_ack_o          = s.ack;
  assign relay_out_zero_o  = s.relays.zero;
  assign relay_out_one_o   = s.relays.one;
  assign relay_out_two_o   = s.relays.two;
  assign relay_out_three_o = s.relays.three;
  assign out_24v_o         = s.out_24v;

endmodule

// [common/starter_pkg.sv]
package starter_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
  localparam logic [15:0] MIN_STAR_MS   = 16'h03E8; // 1000 ms, earliest changeover
  localparam logic [15:0] CHANGE_GAP_MS = 16'h0032; // 50 ms dead time star to delta
  localparam logic [15:0] CHECKBACK_MS  = 16'h012C; // 300 ms checkback tolerance

  ////////////////////////////////////////////////////////////////////////////
  // current scaling
  localparam logic [7:0]  CUR_FACTOR_DELTA  = 8'h64; // 100
  localparam logic [7:0]  CUR_FACTOR_ROOT3  = 8'hAD; // 173
  localparam logic [15:0] MAX_CURRENT_PCT   = 16'h0320; // 800 %
  localparam logic [15:0] OVERLOAD_WARN_PCT = 16'h0073; // 115 %

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADR_CONFIG       = 8'h00;
  localparam logic [7:0] ADR_STAR_TIME    = 8'h04;
  localparam logic [7:0] ADR_SWITCH_LEVEL = 8'h08;
  localparam logic [7:0] ADR_RATED_ONE    = 8'h0C;
  localparam logic [7:0] ADR_RATED_TWO    = 8'h10;
  localparam logic [7:0] ADR_CT_RATIO     = 8'h14;
  localparam logic [7:0] ADR_COMMAND      = 8'h18;
  localparam logic [7:0] ADR_MONITOR      = 8'h1C;
  localparam logic [7:0] ADR_OUTPUTS      = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // command word bits (byte one in bits 15:8)
  localparam int unsigned CMD_OFF         = 1;
  localparam int unsigned CMD_RUN_FWD     = 2;
  localparam int unsigned CMD_EMERG_START = 4;
  localparam int unsigned CMD_AUTO        = 5;
  localparam int unsigned CMD_FAULT_RESET = 6;
  localparam int unsigned CMD_RUN_FAST    = 9;
  localparam int unsigned CMD_OUT_24V     = 12;

  ////////////////////////////////////////////////////////////////////////////
  // field types
  typedef enum logic {FUNC_STAR_DELTA, FUNC_POLE_CHANGE} func_t;
  typedef enum logic {SWITCH_BY_TIME, SWITCH_BY_CURRENT} switch_mode_t;

  typedef struct packed {
    logic         fault_on_24v;
    logic         pole_fault_relay_three;
    logic         fault_out_en;
    logic         local_en;
    logic         checkback_en;
    logic         dip_ride_en;
    logic         root3;
    switch_mode_t star_delta_switch_mode;
    func_t        function_sel;
  } config_t;

  // order matches monitor byte one bits 7..2
  typedef struct packed {
    logic local_stop;
    logic local_start;
    logic speed_two_start;
    logic aux_two;
    logic aux_one;
    logic checkback;
  } pin_in_t;

  typedef struct packed {
    logic three;
    logic two;
    logic one;
    logic zero;
  } relay_t;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam config_t     RST_CONFIG       = config_t'(9'h000);
  localparam logic [15:0] RST_STAR_TIME    = 16'h1388; // 5000 ms
  localparam logic [15:0] RST_SWITCH_LEVEL = 16'h00C8; // 200 %
  localparam logic [15:0] RST_RATED        = 16'h0064;
  localparam logic [7:0]  RST_CT_RATIO     = 8'h01;

endpackage

// [design/current_scaler.sv]
`timescale 1ns/1ps
// serial divider: pct = sample * factor / rated, clamped to the top of range
module current_scaler (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // operands
  input  wire logic [15:0] sample_i,
  input  wire logic [15:0] factor_i,
  input  wire logic [15:0] rated_i,
  // result
  output logic      [15:0] pct_o,
  output logic             valid_o
);

  typedef struct packed {
    logic        busy;
    logic [5:0]  step;
    logic [31:0] num;
    logic [16:0] rem;
    logic [15:0] divisor;
    logic [15:0] pct;
    logic        valid;
  } scale_state_t;

  scale_state_t s;
  scale_state_t nxt_s;
  logic [16:0]  rem_sh;

  ////////////////////////////////////////////////////////////////////////////
  // one quotient bit per cycle; a fresh result every 34 cycles is plenty
  always_comb begin
    nxt_s  = s;
    rem_sh = {s.rem[15:0], s.num[31]};
    if (!s.busy) begin
      nxt_s.busy    = 1'b1;
      nxt_s.step    = 6'h00;
      nxt_s.num     = 32'(sample_i) * 32'(factor_i);
      nxt_s.rem     = 17'h00000;
      nxt_s.divisor = rated_i;
    end else if (s.step != 6'h20) begin
      nxt_s.step = s.step + 6'h01;
      if (rem_sh >= {1'b0, s.divisor}) begin
        nxt_s.rem = rem_sh - {1'b0, s.divisor};
        nxt_s.num = {s.num[30:0], 1'b1};
      end else begin
        nxt_s.rem = rem_sh;
        nxt_s.num = {s.num[30:0], 1'b0};
      end
    end else begin
      // zero rated current would divide by zero: report full scale instead
      if (s.divisor == 16'h0000 || s.num > {16'h0000, starter_pkg::MAX_CURRENT_PCT}) begin
        nxt_s.pct = starter_pkg::MAX_CURRENT_PCT;
      end else begin
        nxt_s.pct = s.num[15:0];
      end
      nxt_s.valid = 1'b1;
      nxt_s.busy  = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
    end else begin
      s <= nxt_s;
    end
  end

  assign pct_o   = s.pct;
  assign valid_o = s.valid;

endmodule

// [test/star_delta_pole_starter_properties.sv]
`timescale 1ns/1ps
module star_delta_pole_starter_properties #(
  parameter int unsigned MS_TICK_CYCLES = starter_pkg::MS_CYCLES
) (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        relay_out_zero_o,
  input wire logic        relay_out_one_o,
  input wire logic        relay_out_two_o,
  input wire logic        relay_out_three_o,
  input wire logic        out_24v_o
);
  localparam int unsigned MIN_CYC = starter_pkg::MIN_STAR_MS * MS_TICK_CYCLES;
  logic [31:0] main_on_ff;
  // cycles the main contactor has held; saturates so long runs cannot wrap
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      main_on_ff <= 32'h0;
    end else if (!relay_out_two_o) begin
      main_on_ff <= 32'h0;
    end else if (main_on_ff != 32'hFFFFFFFF) begin
      main_on_ff <= main_on_ff + 32'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_ack_s;
    wb_ack_o && !wb_we_i;
  endsequence
  AST_ACK_NEXT:
    assert property (req_s |=> wb_ack_o) else $error("ack late");
  AST_ACK_ONE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_IDLE:
    assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  AST_UNMAPPED_ZERO:
    assert property (rd_ack_s ##0 wb_adr_i > 8'h20 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_MONITOR_FIELDS:
    assert property (rd_ack_s ##0 wb_adr_i == starter_pkg::ADR_MONITOR |->
      wb_dat_o[31:16] <= starter_pkg::MAX_CURRENT_PCT && !wb_dat_o[4] && !wb_dat_o[0])
    else $error("monitor word malformed");
  AST_IDLE_AFTER_RESET:
    assert property (!$past(arst_n_i) |-> {relay_out_three_o, relay_out_two_o,
      relay_out_one_o, relay_out_zero_o, out_24v_o} == 5'h00)
    else $error("outputs not idle after reset");
  AST_EXCLUSIVE:
    assert property (!(relay_out_zero_o && relay_out_one_o)) else $error("both on");
  AST_STAR_FIRST:
    assert property ($rose(relay_out_one_o) |->
      !relay_out_zero_o && !$past(relay_out_zero_o, 8))
    else $error("no gap before delta");
  AST_MIN_STAR:
    assert property ($rose(relay_out_one_o) && relay_out_two_o |-> main_on_ff >= MIN_CYC)
    else $error("delta too early");
endmodule
bind star_delta_pole_starter star_delta_pole_starter_properties #(
  .MS_TICK_CYCLES(MS_TICK_CYCLES)
) star_delta_pole_starter_properties_inst (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .relay_out_zero_o(relay_out_zero_o), .relay_out_one_o(relay_out_one_o),
  .relay_out_two_o(relay_out_two_o), .relay_out_three_o(relay_out_three_o),
  .out_24v_o(out_24v_o)
);

// [test/contactor_motor_model.sv]
`timescale 1ns/1ps
// contactors plus motor: checkback follows the coils, current shows inrush
module contactor_motor_model #(
  parameter int unsigned INRUSH_CYC = 5000
) (
  input  wire logic        clk_i,
  input  wire logic [2:0]  coils_i,
  input  wire logic        stuck_open_i,
  output logic             checkback_o,
  output logic      [15:0] sample_o
);
  int unsigned run_cnt;
  // a broken auxiliary contact reads open even with the coil energised
  assign checkback_o = (|coils_i) & !stuck_open_i;
  // starting current only falls once the motor has run up
  always_ff @(posedge clk_i) begin
    if (!(|coils_i)) begin
      run_cnt <= 0;
    end else if (run_cnt < INRUSH_CYC) begin
      run_cnt <= run_cnt + 1;
    end
  end
  assign sample_o = !(|coils_i) ? 16'h0000 : (run_cnt < INRUSH_CYC) ? 16'h01F4 : 16'h0064;
endmodule

// [test/star_delta_pole_starter_bench.sv]
`timescale 1ns/1ps
module star_delta_pole_starter_bench;
  localparam int MS = 10;
  logic        clk_i = 1'b0, arst_n_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        dip = 1'b0, stuck = 1'b0, ack, cb, r0, r1, r2, r3, v24;
  logic [2:0]  btn = 3'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, d;
  logic [15:0] amps;
  logic [4:0]  pins;
  int          err_count = 0, samples_checked = 0;
  assign pins = {v24, r3, r2, r1, r0};
  star_delta_pole_starter #(.MS_TICK_CYCLES(MS)) star_delta_pole_starter_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .checkback_input_i(cb), .aux_input_one_i(1'b0), .aux_input_two_i(1'b0),
    .speed_two_start_input_i(btn[0]), .local_start_input_i(btn[1]),
    .local_stop_input_i(btn[2]), .supply_dip_i(dip), .current_sample_i(amps),
    .relay_out_zero_o(r0), .relay_out_one_o(r1), .relay_out_two_o(r2),
    .relay_out_three_o(r3), .out_24v_o(v24));
  contactor_motor_model #(.INRUSH_CYC(500 * MS)) contactor_motor_model_inst (
    .clk_i(clk_i), .coils_i({r2, r1, r0}), .stuck_open_i(stuck), .checkback_o(cb),
    .sample_o(amps));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ms(input int n);
    repeat (n * MS) @(posedge clk_i);
  endtask
  // data is taken at the rising edge that sees ack high; the request drops there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do @(posedge clk_i); while (ack !== 1'b1);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(d, e);
  endtask
  task automatic pchk(input logic [4:0] e);
    ms(1);
    @(negedge clk_i);
    chk({27'h0, pins}, {27'h0, e});
  endtask
  task automatic press(input int b);
    @(posedge clk_i);
    btn[b] <= 1'b1;
    ms(2);
    btn[b] <= 1'b0;
    ms(2);
  endtask
  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk(starter_pkg::ADR_STAR_TIME, 32'h1388);
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    rchk(8'h40, 32'h0);
    bus(1'b1, starter_pkg::ADR_OUTPUTS, 32'h1F);
    pchk(5'h00);
    bus(1'b1, starter_pkg::ADR_COMMAND, 32'h1000);
    pchk(5'h10);
  endtask
  task automatic t_time();
    bus(1'b1, starter_pkg::ADR_STAR_TIME, 32'hA);
    bus(1'b1, starter_pkg::ADR_COMMAND, 32'h24);
    ms(900);
    pchk(5'h05);
    ms(200);
    pchk(5'h06);
    bus(1'b1, starter_pkg::ADR_COMMAND, 32'h22);
    pchk(5'h00);
  endtask
  // current mode with a long star time: only the current can end star early
  task automatic t_current();
    bus(1'b1, starter_pkg::ADR_CONFIG, 32'hE);
    bus(1'b1, starter_pkg::ADR_STAR_TIME, 32'h1388);
    bus(1'b1, starter_pkg::ADR_COMMAND, 32'h24);
    ms(200);
    rchk(starter_pkg::ADR_MONITOR, 32'h0320048C);
    ms(1300);
    pchk(5'h06);
    rchk(starter_pkg::ADR_MONITOR, 32'h00AD048C);
    @(posedge clk_i);
    dip <= 1'b1;
    pchk(5'h00);
    @(posedge clk_i);
    dip <= 1'b0;
    bus(1'b1, starter_pkg::ADR_COMMAND, 32'h62);
  endtask
  task automatic t_pole();
    bus(1'b1, starter_pkg::ADR_CONFIG, 32'h21);
    bus(1'b1, starter_pkg::ADR_RATED_TWO, 32'h32);
    bus(1'b1, starter_pkg::ADR_COMMAND, 32'h0);
    press(1);
    pchk(5'h01);
    press(0);
    pchk(5'h01);
    press(2);
    pchk(5'h00);
    press(0);
    ms(600);
    pchk(5'h02);
    bus(1'b0, starter_pkg::ADR_MONITOR, 32'h0);
    chk(d & 32'hFFFF0200, 32'h00C80200);
    press(2);
  endtask
  // broken checkback: star-delta lamps relay three, pole mode relay two, then relay three
  task automatic t_fault();
    stuck <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, starter_pkg::ADR_CONFIG, i == 0 ? 32'h150 : i == 1 ? 32'h151 : 32'h1D1);
      bus(1'b1, starter_pkg::ADR_COMMAND, 32'h24);
      ms(400);
      pchk(i == 1 ? 5'h14 : 5'h18);
      bus(1'b1, starter_pkg::ADR_COMMAND, 32'h62);
      pchk(5'h00);
    end
    stuck <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_time();
    t_current();
    t_pole();
    t_fault();
    end_of_test();
  end
  // the whole sequence needs about 45000 cycles
  initial begin
    repeat (70000) @(posedge clk_i);
    err_count++;
    end_of_test();
  end
endmodule
